// ### hdl/cond_eval.v
`timescale 1ns/1ns
`default_nettype none
`include "opdec_regs.vh"

// Flag test shared by branches and conditional returns.
// Code: 0 ge_s 1 gt_s 2 lt_s 3 le_s 4 eq 5 ne 6 ge_u 7 gt_u
//       8 lt_u 9 le_u 10 vc 11 vs 12 always
module cond_eval
(
    input wire [3:0] code,
    input wire [3:0] flags,
    output reg holds
);
    wire n = flags[3];
    wire z = flags[2];
    wire c = flags[1];
    wire v = flags[0];

    always @*
    begin
        case (code)
            4'h0: holds = (n == v) || z;
            4'h1: holds = (n == v) && !z;
            4'h2: holds = (n != v) && !z;
            4'h3: holds = (n != v) || z;
            4'h4: holds = z;
            4'h5: holds = !z;
            4'h6: holds = !c;
            4'h7: holds = !c && !z;
            4'h8: holds = c;
            4'h9: holds = c || z;
            4'ha: holds = !v;
            4'hb: holds = v;
            4'hc: holds = 1'b1;
            default: holds = 1'b0;
        endcase
    end
endmodule // cond_eval

`default_nettype wire

// ### hdl/opcode_decoder.v
`timescale 1ns/1ns
`default_nettype none
`include "opdec_regs.vh"

module opcode_decoder
(
    input wire clk_sys,
    input wire rst,
    input wire op_valid,
    input wire [7:0] op_byte,
    input wire kernel_level,
    input wire [31:0] processor_status_word,
    input wire reload_flag,
    input wire [3:0] reg_count,
    output reg dec_valid,
    output reg [3:0] dec_class,
    output reg [7:0] dec_opcode,
    output reg [7:0] dec_ext,
    output reg [3:0] dec_length,
    output reg [3:0] dec_length_max,
    output reg [8:0] cyc_min,
    output reg [8:0] cyc_max,
    output reg xfer_taken,
    output reg coproc_req,
    output reg [1:0] coproc_words,
    output reg priv_fault,
    output reg flags_keep,
    output reg [3:0] flags_out
);
    localparam ST_FIRST = 1'b0;
    localparam ST_SECOND = 1'b1;

    reg state;
    reg [7:0] prefix;
    reg [3:0] cond_code;
    wire cond_holds;

    reg next_valid;
    reg [3:0] next_class;
    reg [7:0] next_ext;
    reg [3:0] next_len;
    reg [3:0] next_len_max;
    reg [8:0] next_cmin;
    reg [8:0] next_cmax;
    reg next_taken;
    reg next_cp;
    reg [1:0] next_cpw;
    reg next_fault;
    reg next_keep;
    reg next_state;
    reg is_branch;
    reg is_half;
    reg is_cx;

    cond_eval u_cond
    (
        .code(cond_code),
        .flags(processor_status_word[`FLAG_MSB:`FLAG_LSB]),
        .holds(cond_holds)
    );

    // Condition selector; aliased opcodes share one code, so one behaviour
    always @*
    begin
        is_branch = 1'b0;
        is_half = 1'b0;
        is_cx = 1'b0;
        cond_code = 4'hf;
        case (op_byte)
            `OP_BR_LE_S_B, `OP_BR_LE_S_B - 8'h01: cond_code = 4'h3;
            `OP_BR_GT_S_B, `OP_BR_GT_S_B - 8'h01: cond_code = 4'h1;
            `OP_BR_GE_S_B, `OP_BR_GE_S_B - 8'h01: cond_code = 4'h0;
            `OP_BR_LT_S_B, `OP_BR_LT_S_B - 8'h01: cond_code = 4'h2;
            `OP_BR_LT_U_B, `OP_BR_LT_U_B - 8'h01: cond_code = 4'h8;
            `OP_BR_LE_U_B, `OP_BR_LE_U_B - 8'h01: cond_code = 4'h9;
            `OP_BR_GT_U_B, `OP_BR_GT_U_B - 8'h01: cond_code = 4'h7;
            `OP_BR_GE_U_B, `OP_BR_GE_U_B - 8'h01: cond_code = 4'h6;
            `OP_BR_VC_B, `OP_BR_VC_B - 8'h01: cond_code = 4'ha;
            `OP_BR_VS_B, `OP_BR_VS_B - 8'h01: cond_code = 4'hb;
            `OP_BR_EQ_B, `OP_BR_EQ_B - 8'h01,
            `OP_BR_EQ_DUP_B, `OP_BR_EQ_DUP_B - 8'h01: cond_code = 4'h4;
            `OP_BR_NE_B, `OP_BR_NE_B - 8'h01,
            `OP_BR_NE_DUP_B, `OP_BR_NE_DUP_B - 8'h01: cond_code = 4'h5;
            `OP_SUB_BR_B, `OP_SUB_BR_H: cond_code = 4'hc;
            `OP_CX_GE_S: cond_code = 4'h0;
            `OP_CX_GT_S: cond_code = 4'h1;
            `OP_CX_LT_S: cond_code = 4'h2;
            `OP_CX_LE_S: cond_code = 4'h3;
            `OP_CX_EQ_S, `OP_CX_EQ_U: cond_code = 4'h4;
            `OP_CX_NE_S, `OP_CX_NE_U: cond_code = 4'h5;
            `OP_CX_GE_U: cond_code = 4'h6;
            `OP_CX_GT_U: cond_code = 4'h7;
            `OP_CX_LE_U: cond_code = 4'h9;
            `OP_CX_CS: cond_code = 4'h8;
            `OP_CX_VC: cond_code = 4'ha;
            `OP_CX_VS: cond_code = 4'hb;
            default: cond_code = 4'hf;
        endcase
        if (op_byte[7:4] >= 4'h4 && op_byte[7:4] <= 4'h7 && op_byte[1:0] != 2'b00
            && cond_code != 4'hf)
        begin
            is_branch = 1'b1;
            is_half = !op_byte[0];
        end
        if (op_byte == `OP_SUB_BR_B || op_byte == `OP_SUB_BR_H)
        begin
            is_branch = 1'b1;
            is_half = !op_byte[0];
        end
        if (op_byte[1:0] == 2'b00 && cond_code != 4'hf)
            is_cx = 1'b1;
    end

    always @*
    begin
        next_valid = 1'b0;
        next_class = `CLS_NONE;
        next_ext = 8'h00;
        next_len = 4'h1;
        next_len_max = 4'h1;
        next_cmin = 9'd0;
        next_cmax = 9'd0;
        next_taken = 1'b0;
        next_cp = 1'b0;
        next_cpw = 2'd0;
        next_fault = 1'b0;
        next_keep = 1'b1;
        next_state = state;
        if (op_valid)
        begin
            case (state)
                ST_FIRST:
                begin
                    next_valid = 1'b1;
                    if (is_branch)
                    begin
                        next_class = `CLS_BRANCH;
                        next_len = is_half ? 4'h3 : 4'h2;
                        next_len_max = next_len;
                        next_taken = cond_holds;
                        if (!cond_holds)
                        begin
                            next_cmin = `CYC_BR_NT_MIN;
                            next_cmax = `CYC_BR_NT_MAX;
                        end
                        else if (is_half)
                        begin
                            next_cmin = `CYC_BR_H_MIN;
                            next_cmax = `CYC_BR_H_MAX;
                        end
                        else
                        begin
                            next_cmin = `CYC_BR_B_MIN;
                            next_cmax = `CYC_BR_B_MAX;
                        end
                        if (op_byte == `OP_SUB_BR_B || op_byte == `OP_SUB_BR_H)
                            next_class = `CLS_SUBR;
                    end
                    else if (is_cx)
                    begin
                        next_class = `CLS_COND_RET;
                        next_taken = cond_holds;
                        next_cmin = cond_holds ? `CYC_CX_T_MIN : `CYC_CX_NT_MIN;
                        next_cmax = cond_holds ? `CYC_CX_T_MAX : `CYC_CX_NT_MAX;
                    end
                    else
                    begin
                        case (op_byte)
                            `OP_SUB_JMP:
                            begin
                                next_class = `CLS_SUBR;
                                next_len = 4'h2;
                                next_len_max = 4'h6;
                                next_taken = 1'b1;
                            end
                            `OP_SUB_EXIT:
                            begin
                                next_class = `CLS_SUBR;
                                next_taken = 1'b1;
                                next_cmin = `CYC_CX_T_MIN;
                                next_cmax = `CYC_CX_T_MAX;
                            end
                            `OP_REG_SAVE, `OP_REG_RESTORE:
                            begin
                                next_class = `CLS_PROC;
                                next_len = 4'h2;
                                next_len_max = 4'h2;
                                // Two cycles more per register moved
                                next_cmin = (op_byte == `OP_REG_SAVE ? `CYC_SAVE_BASE
                                    : `CYC_RESTORE_BASE) + {4'h0, reg_count, 1'b0};
                                next_cmax = next_cmin + 9'd1;
                            end
                            `OP_PROC_CALL, `OP_PROC_EXIT:
                            begin
                                next_class = `CLS_PROC;
                                next_taken = 1'b1;
                                next_len = op_byte[2] ? 4'h7 : 4'h1;
                                next_len_max = next_len;
                            end
                            `OP_PUSH_EA, `OP_PUSH_WORD, `OP_POP_WORD:
                            begin
                                next_class = `CLS_STACK;
                                next_len = 4'h2;
                                next_len_max = 4'h6;
                            end
                            `OP_NOP1, `OP_NOP2, `OP_NOP3:
                            begin
                                next_class = `CLS_NOP;
                                next_len = (op_byte == `OP_NOP1) ? 4'h1
                                    : (op_byte == `OP_NOP2 ? 4'h2 : 4'h3);
                                next_len_max = next_len;
                            end
                            `OP_CP_OP:
                            begin
                                next_class = `CLS_COPROC;
                                next_cp = 1'b1;
                                next_len = 4'h5;
                                next_len_max = 4'h5;
                            end
                            `OP_CP_RD_S, `OP_CP_RD_D, `OP_CP_RD_T,
                            `OP_CP_WR_S, `OP_CP_WR_D, `OP_CP_WR_T:
                            begin
                                next_class = `CLS_COPROC;
                                next_cp = 1'b1;
                                next_keep = 1'b0;
                                next_len = 4'h6;
                                next_len_max = 4'ha;
                                next_cpw = (op_byte[2] ? 2'd3 : (op_byte[5] ? 2'd1 : 2'd2));
                            end
                            `OP_CP_2A_S, `OP_CP_2A_D, `OP_CP_2A_T:
                            begin
                                next_class = `CLS_COPROC;
                                next_cp = 1'b1;
                                next_keep = 1'b0;
                                next_len = 4'h7;
                                next_len_max = 4'hf;
                                next_cpw = (op_byte[2] ? 2'd3 : (op_byte[5] ? 2'd1 : 2'd2));
                            end
                            `OP_MOVE_XLATED:
                            begin
                                next_class = `CLS_OS;
                                next_keep = 1'b0;
                                next_len = 4'h9;
                                next_len_max = 4'h9;
                            end
                            `OP_WAIT_INT:
                            begin
                                next_class = kernel_level ? `CLS_OS : `CLS_PRIV_FAULT;
                                next_fault = !kernel_level;
                            end
                            `OP_OS_PREFIX:
                            begin
                                // Result waits for the second opcode byte
                                next_valid = 1'b0;
                                next_state = ST_SECOND;
                            end
                            default:
                                next_class = `CLS_NONE;
                        endcase
                    end
                end
                ST_SECOND:
                begin
                    next_valid = 1'b1;
                    next_state = ST_FIRST;
                    next_ext = op_byte;
                    next_len = 4'h2;
                    next_len_max = 4'h2;
                    next_class = `CLS_OS;
                    case (op_byte)
                        `OP2_GATE, `OP2_GATE_EXIT:
                        begin
                            next_keep = 1'b0;
                            next_taken = 1'b1;
                        end
                        `OP2_VPIN_ON, `OP2_VPIN_OFF, `OP2_INT_ACK:
                        begin
                            next_fault = !kernel_level;
                            next_taken = kernel_level && (op_byte != `OP2_INT_ACK);
                        end
                        `OP2_PROC_INVOKE:
                        begin
                            next_fault = !kernel_level;
                            next_keep = 1'b0;
                            next_taken = kernel_level;
                            next_cmin = reload_flag ? `CYC_INVOKE_R_MIN : `CYC_INVOKE_MIN;
                            next_cmax = reload_flag ? `CYC_INVOKE_R_MAX : `CYC_INVOKE_MAX;
                        end
                        `OP2_PROC_RESUME:
                        begin
                            next_fault = !kernel_level;
                            next_keep = 1'b0;
                            next_taken = kernel_level;
                            next_cmin = reload_flag ? `CYC_RESUME_R_MIN : `CYC_RESUME_MIN;
                            next_cmax = reload_flag ? `CYC_RESUME_R_MAX : `CYC_RESUME_MAX;
                        end
                        default:
                            next_class = `CLS_NONE;
                    endcase
                    if (next_fault)
                    begin
                        next_class = `CLS_PRIV_FAULT;
                        next_keep = 1'b1;
                        next_cmin = 9'd0;
                        next_cmax = 9'd0;
                    end
                end
                default:
                    next_state = ST_FIRST;
            endcase
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_FIRST;
            prefix <= 8'h00;
            dec_valid <= 1'b0;
            dec_class <= `CLS_NONE;
            dec_opcode <= 8'h00;
            dec_ext <= 8'h00;
            dec_length <= 4'h0;
            dec_length_max <= 4'h0;
            cyc_min <= 9'd0;
            cyc_max <= 9'd0;
            xfer_taken <= 1'b0;
            coproc_req <= 1'b0;
            coproc_words <= 2'd0;
            priv_fault <= 1'b0;
            flags_keep <= 1'b1;
            flags_out <= 4'h0;
        end
        else
        begin
            state <= next_state;
            if (op_valid && state == ST_FIRST)
                prefix <= op_byte;
            dec_valid <= next_valid;
            dec_class <= next_class;
            dec_opcode <= (state == ST_SECOND) ? prefix : op_byte;
            dec_ext <= next_ext;
            dec_length <= next_len;
            dec_length_max <= next_len_max;
            cyc_min <= next_cmin;
            cyc_max <= next_cmax;
            xfer_taken <= next_taken;
            coproc_req <= next_cp;
            coproc_words <= next_cpw;
            priv_fault <= next_fault;
            flags_keep <= next_keep;
            flags_out <= processor_status_word[`FLAG_MSB:`FLAG_LSB];
        end
    end
endmodule // opcode_decoder

`default_nettype wire

// ### hdl/opdec_regs.vh
`ifndef OPDEC_REGS_VH
`define OPDEC_REGS_VH

// Opcode values of the decoded groups
`define OP_BR_LE_S_B 8'h4f
`define OP_BR_GT_S_B 8'h47
`define OP_BR_GE_S_B 8'h43
`define OP_BR_LT_S_B 8'h4b
`define OP_BR_LT_U_B 8'h5b
`define OP_BR_LE_U_B 8'h5f
`define OP_BR_GT_U_B 8'h57
`define OP_BR_GE_U_B 8'h53
`define OP_BR_VC_B 8'h63
`define OP_BR_VS_B 8'h6b
`define OP_BR_EQ_B 8'h7f
`define OP_BR_EQ_DUP_B 8'h6f
`define OP_BR_NE_B 8'h77
`define OP_BR_NE_DUP_B 8'h67
`define OP_CX_GE_S 8'h40
`define OP_CX_GT_S 8'h44
`define OP_CX_LT_S 8'h48
`define OP_CX_LE_S 8'h4c
`define OP_CX_EQ_S 8'h7c
`define OP_CX_NE_S 8'h74
`define OP_CX_GE_U 8'h50
`define OP_CX_GT_U 8'h54
`define OP_CX_LE_U 8'h5c
`define OP_CX_EQ_U 8'h6c
`define OP_CX_NE_U 8'h64
`define OP_CX_VC 8'h60
`define OP_CX_VS 8'h68
`define OP_CX_CS 8'h58
`define OP_SUB_BR_B 8'h37
`define OP_SUB_BR_H 8'h36
`define OP_SUB_JMP 8'h34
`define OP_SUB_EXIT 8'h78
`define OP_REG_SAVE 8'h10
`define OP_REG_RESTORE 8'h18
`define OP_PROC_CALL 8'h2c
`define OP_PROC_EXIT 8'h08
`define OP_PUSH_EA 8'he0
`define OP_PUSH_WORD 8'ha0
`define OP_POP_WORD 8'h20
`define OP_NOP1 8'h70
`define OP_NOP2 8'h73
`define OP_NOP3 8'h72
`define OP_CP_OP 8'h32
`define OP_CP_RD_S 8'h22
`define OP_CP_RD_D 8'h02
`define OP_CP_RD_T 8'h06
`define OP_CP_2A_S 8'h23
`define OP_CP_2A_D 8'h03
`define OP_CP_2A_T 8'h07
`define OP_CP_WR_S 8'h33
`define OP_CP_WR_D 8'h13
`define OP_CP_WR_T 8'h17
`define OP_MOVE_XLATED 8'h0c
`define OP_WAIT_INT 8'h2f
`define OP_OS_PREFIX 8'h30
`define OP2_GATE 8'h61
`define OP2_GATE_EXIT 8'h45
`define OP2_VPIN_ON 8'h0d
`define OP2_VPIN_OFF 8'h13
`define OP2_INT_ACK 8'h2f
`define OP2_PROC_INVOKE 8'hac
`define OP2_PROC_RESUME 8'hc8

// Condition flag field of the status word
`define FLAG_LSB 18
`define FLAG_MSB 21

// Cycle budgets
`define CYC_BR_NT_MIN 9'd5
`define CYC_BR_NT_MAX 9'd10
`define CYC_BR_B_MIN 9'd7
`define CYC_BR_B_MAX 9'd14
`define CYC_BR_H_MIN 9'd7
`define CYC_BR_H_MAX 9'd12
`define CYC_CX_NT_MIN 9'd4
`define CYC_CX_NT_MAX 9'd5
`define CYC_CX_T_MIN 9'd13
`define CYC_CX_T_MAX 9'd14
`define CYC_SAVE_BASE 9'd11
`define CYC_RESTORE_BASE 9'd12
`define CYC_INVOKE_MIN 9'd224
`define CYC_INVOKE_MAX 9'd226
`define CYC_INVOKE_R_MIN 9'd302
`define CYC_INVOKE_R_MAX 9'd304
`define CYC_RESUME_MIN 9'd189
`define CYC_RESUME_MAX 9'd191
`define CYC_RESUME_R_MIN 9'd277
`define CYC_RESUME_R_MAX 9'd279

// Instruction classes
`define CLS_NONE 4'h0
`define CLS_BRANCH 4'h1
`define CLS_COND_RET 4'h2
`define CLS_SUBR 4'h3
`define CLS_PROC 4'h4
`define CLS_STACK 4'h5
`define CLS_NOP 4'h6
`define CLS_COPROC 4'h7
`define CLS_OS 4'h8
`define CLS_PRIV_FAULT 4'h9

`endif

// ### tb/fetch_model.sv
`timescale 1ns/1ns
`default_nettype none
module fetch_model
(
    input wire logic clk_sys,
    output logic op_valid,
    output logic [7:0] op_byte
);
    initial
    begin
        op_valid = 1'b0;
        op_byte = 8'h00;
    end
    task automatic send(input logic [7:0] b);
        @(negedge clk_sys);
        op_valid = 1'b1;
        op_byte = b;
    endtask
    // Released byte lane inverts so a stale opcode never decodes by luck
    task automatic idle();
        @(negedge clk_sys);
        op_valid = 1'b0;
        op_byte = ~op_byte;
    endtask
endmodule // fetch_model
`default_nettype wire

// ### tb/opdec_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module opdec_monitor
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic kernel_level,
    input wire logic reload_flag,
    input wire logic [31:0] processor_status_word,
    input wire logic dec_valid,
    input wire logic [3:0] dec_class,
    input wire logic [7:0] dec_ext,
    input wire logic [3:0] dec_length,
    input wire logic [8:0] cyc_min,
    input wire logic [8:0] cyc_max,
    input wire logic xfer_taken,
    input wire logic coproc_req,
    input wire logic priv_fault,
    input wire logic flags_keep,
    input wire logic [3:0] flags_out
);
    wire [3:0] sw_flags = processor_status_word[21:18];
    wire os_valid = dec_valid && dec_class == 4'h8;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_priv;
        priv_fault |-> !$past(kernel_level) && dec_class == 4'h9 && !xfer_taken;
    endproperty
    a_priv: assert property (p_priv) else $error("fault at kernel level");
    property p_branch;
        dec_valid && dec_class == 4'h1 |-> {cyc_min, cyc_max} == (xfer_taken ?
            {9'd7, (dec_length == 4'd2) ? 9'd14 : 9'd12} : {9'd5, 9'd10});
    endproperty
    a_branch: assert property (p_branch) else $error("branch budget");
    property p_cexit;
        dec_valid && dec_class == 4'h2 |-> {cyc_min, cyc_max} ==
            (xfer_taken ? {9'd13, 9'd14} : {9'd4, 9'd5});
    endproperty
    a_cexit: assert property (p_cexit) else $error("return budget");
    property p_flags;
        !$past(rst) |-> flags_out == $past(sw_flags);
    endproperty
    a_flags: assert property (p_flags) else $error("flag field");
    property p_coproc;
        dec_valid |-> coproc_req == (dec_class == 4'h7);
    endproperty
    a_coproc: assert property (p_coproc) else $error("coprocessor routing");
    property p_invoke;
        os_valid && dec_ext == 8'hac |-> {cyc_min, cyc_max} ==
            ($past(reload_flag) ? {9'd302, 9'd304} : {9'd224, 9'd226});
    endproperty
    a_invoke: assert property (p_invoke) else $error("invoke budget");
    property p_resume;
        os_valid && dec_ext == 8'hc8 |-> {cyc_min, cyc_max} ==
            ($past(reload_flag) ? {9'd277, 9'd279} : {9'd189, 9'd191});
    endproperty
    a_resume: assert property (p_resume) else $error("resume budget");
    property p_keep;
        dec_valid && dec_class inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6} |-> flags_keep;
    endproperty
    a_keep: assert property (p_keep) else $error("flags not kept");
endmodule // opdec_monitor
bind opcode_decoder opdec_monitor i_opdec_monitor (.clk_sys, .rst, .kernel_level,
    .reload_flag, .processor_status_word, .dec_valid, .dec_class, .dec_ext, .dec_length,
    .cyc_min, .cyc_max, .xfer_taken, .coproc_req, .priv_fault, .flags_keep, .flags_out);
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic kernel_level = 1'b0;
    logic reload_flag = 1'b0;
    logic [3:0] reg_count = 4'd0;
    logic [31:0] processor_status_word = 32'h0;
    wire op_valid, dec_valid, xfer_taken, coproc_req, priv_fault, flags_keep;
    wire [7:0] op_byte, dec_opcode, dec_ext;
    wire [3:0] dec_class, dec_length, dec_length_max, flags_out;
    wire [8:0] cyc_min, cyc_max;
    wire [1:0] coproc_words;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    always #50 clk_sys = ~clk_sys;
    fetch_model i_fetch_model (.clk_sys, .op_valid, .op_byte);
    opcode_decoder i_opcode_decoder (.clk_sys, .rst, .op_valid, .op_byte, .kernel_level,
        .processor_status_word, .reload_flag, .reg_count, .dec_valid, .dec_class,
        .dec_opcode, .dec_ext, .dec_length, .dec_length_max, .cyc_min, .cyc_max,
        .xfer_taken, .coproc_req, .coproc_words, .priv_fault, .flags_keep, .flags_out);
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Prefixed opcodes go back to back; result is settled on return
    task automatic fetch(input logic [15:0] w);
        if (w[15:8] == 8'h30)
            i_fetch_model.send(8'h30);
        i_fetch_model.send(w[7:0]);
        i_fetch_model.idle();
    endtask
    task automatic res(input logic [3:0] cls, input logic tk, input logic [8:0] mn,
        input logic [8:0] mx);
        chk(dec_valid, 1'b1);
        chk(dec_class, cls);
        chk(xfer_taken, tk);
        chk(cyc_min, mn);
        chk(cyc_max, mx);
    endtask
    task automatic t_branch();
        logic [15:0] tab [14] = '{16'h4f40, 16'h4704, 16'h4308, 16'h5b20, 16'h5f40,
            16'h5702, 16'h5302, 16'h4b80, 16'h6301, 16'h6b10, 16'h7f40, 16'h6f40,
            16'h7704, 16'h6704};
        foreach (tab[i])
        begin
            processor_status_word[21:18] = tab[i][7:4];
            fetch(tab[i][15:8]);
            res(4'h1, 1'b1, 9'd7, 9'd14);
            chk(dec_length, 4'd2);
            fetch(tab[i][15:8] - 8'h01);
            res(4'h1, 1'b1, 9'd7, 9'd12);
            processor_status_word[21:18] = tab[i][3:0];
            fetch(tab[i][15:8]);
            res(4'h1, 1'b0, 9'd5, 9'd10);
        end
        $display("branch test done");
    endtask
    task automatic t_return();
        logic [15:0] tab [14] = '{16'h4008, 16'h4404, 16'h4880, 16'h4c40, 16'h7c40,
            16'h7404, 16'h5002, 16'h5402, 16'h5c20, 16'h6c40, 16'h6404, 16'h6001,
            16'h6810, 16'h5820};
        foreach (tab[i])
        begin
            processor_status_word[21:18] = tab[i][7:4];
            fetch(tab[i][15:8]);
            res(4'h2, 1'b1, 9'd13, 9'd14);
            chk(dec_length, 4'd1);
            processor_status_word[21:18] = tab[i][3:0];
            fetch(tab[i][15:8]);
            res(4'h2, 1'b0, 9'd4, 9'd5);
        end
        $display("return test done");
    endtask
    task automatic t_misc();
        logic [11:0] tab [14] = '{12'h373, 12'h363, 12'h343, 12'h783, 12'h104, 12'h184,
            12'h2c4, 12'h084, 12'he05, 12'ha05, 12'h205, 12'h706, 12'h736, 12'h726};
        reg_count = 4'd5;
        foreach (tab[i])
        begin
            fetch(tab[i][11:4]);
            chk(dec_class, tab[i][3:0]);
            if (i > 10)
                chk(dec_length, 9'(i - 10));
        end
        fetch(8'h78);
        chk({cyc_min, cyc_max}, {9'd13, 9'd14});
        fetch(8'h10);
        chk({cyc_min, cyc_max}, {9'd21, 9'd22});
        fetch(8'h18);
        chk({cyc_min, cyc_max}, {9'd22, 9'd23});
        $display("misc test done");
    endtask
    task automatic t_coproc();
        logic [19:0] tab [10] = '{20'h32055, 20'h2216a, 20'h0226a, 20'h0636a, 20'h2317f,
            20'h0327f, 20'h0737f, 20'h3316a, 20'h1326a, 20'h1736a};
        foreach (tab[i])
        begin
            fetch(tab[i][19:12]);
            chk(dec_class, 4'h7);
            chk(coproc_words, tab[i][9:8]);
            chk({dec_length, dec_length_max}, tab[i][7:0]);
        end
        $display("coprocessor test done");
    endtask
    task automatic t_os();
        logic [15:0] tab [9] = '{16'h000c, 16'h3061, 16'h3045, 16'h002f, 16'h300d,
            16'h3013, 16'h302f, 16'h30ac, 16'h30c8};
        for (int k = 0; k < 2; k++)
        begin
            kernel_level = k[0];
            foreach (tab[i])
            begin
                fetch(tab[i]);
                chk(dec_class, (i > 2 && k == 0) ? 4'h9 : 4'h8);
                chk(priv_fault, i > 2 && k == 0);
                chk({dec_opcode, dec_ext}, (tab[i][15:8] == 8'h30) ? tab[i]
                    : {tab[i][7:0], 8'h00});
            end
        end
        for (int r = 0; r < 2; r++)
        begin
            reload_flag = r[0];
            fetch(16'h30ac);
            chk(cyc_min, r ? 9'd302 : 9'd224);
            fetch(16'h30c8);
            chk(cyc_max, r ? 9'd279 : 9'd191);
        end
        $display("system test done");
    endtask
    // Generous ceiling; the whole sequence needs well under a thousand cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        t_branch();
        t_return();
        t_misc();
        t_coproc();
        t_os();
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
